// File: dv/asfc_control_bench.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module asfc_control_bench;
  import asfc_pkg::*;
  localparam int unsigned SHORT_DELAY [8] = '{0, 2, 4, 8, 16, 32, 64, 128};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic align_pin = 1'b1;
  logic fault_ext = 1'b1;
  logic core_result_valid = 1'b0;
  logic core_range_level = 1'b0;
  logic [15:0] chan_enable = 16'h0001;
  asfc_result_type core_result = '0;
  logic sclk, cs_n, din, dout_rdy, fault_pin_out, fault_pin_oe;
  logic aux_out0_pin, aux_out1_pin, aux_outputs_oe, core_reset, conv_start;
  logic [3:0] conv_channel;
  logic [23:0] v;
  wire logic fault_pin_in;
  int errors = 0;
  int total_checks = 0;
  logic [15:0] pc_tab [6] = '{16'h0807, 16'h0803, 16'h0830, 16'h0838, 16'h0800, 16'h0820};
  logic [4:0] pc_exp [6] = '{5'h1c, 5'h00, 5'h02, 5'h03, 5'h00, 5'h00};

  always #12.5 clk_sys = ~clk_sys;
  // The fault wire has a pull-up, so it is high unless someone drives it.
  assign fault_pin_in = fault_pin_oe ? fault_pin_out : fault_ext;

  asfc_control #(.DELAY_CYCLES(SHORT_DELAY), .CHANNELS(16)) u_dut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
    .cs_n(cs_n), .din(din), .dout_rdy(dout_rdy), .align_pin(align_pin), .fault_pin_in(fault_pin_in),
    .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe), .aux_out0_pin(aux_out0_pin),
    .aux_out1_pin(aux_out1_pin), .aux_outputs_oe(aux_outputs_oe), .chan_enable(chan_enable),
    .core_result(core_result), .core_result_valid(core_result_valid), .core_range_level(core_range_level),
    .core_reset(core_reset), .conv_start(conv_start), .conv_channel(conv_channel));
  asfc_host_model u_host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_rdy(dout_rdy));

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [23:0] dummy;
    u_host.xfer({2'b00, a}, {8'h00, d}, 16, dummy);
  endtask

  task automatic rd(input logic [5:0] a, input int nb, output logic [23:0] r);
    u_host.xfer({2'b01, a}, 24'h0, nb, r);
  endtask

  // Pulse align low, wait for the start, then hand back one result.
  task automatic conv(input logic [23:0] s, input logic [3:0] ch);
    int n;
    n = 0;
    align_pin = 1'b0;
    repeat (8) @(negedge clk_sys);
    @(posedge clk_sys);
    align_pin <= 1'b1;
    while (conv_start !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk(24'({conv_start, conv_channel}), 24'({1'b1, ch}));
    core_result = {s, ch};
    core_result_valid = 1'b1;
    @(negedge clk_sys);
    core_result_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk(24'(dout_rdy), 24'h0);
  endtask

  task automatic give_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence; inputs change on falling clock edges, except align_pin, which rises on a rising edge.
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    conv(24'h123456, 4'h0);
    rd(ADDR_DATA, 24, v);
    chk(v, 24'h123456);
    chk(24'(u_host.tail_bit), 24'h1);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_PIN_CONFIG, pc_tab[i]);
      repeat (6) @(negedge clk_sys);
      chk(24'({aux_outputs_oe, aux_outputs_oe & aux_out0_pin, aux_outputs_oe & aux_out1_pin, fault_pin_oe,
        fault_pin_oe & fault_pin_out}), 24'(pc_exp[i]));
    end
    core_range_level = 1'b1;
    conv(24'hffffff, 4'h0);
    chk(24'({fault_pin_oe, fault_pin_out}), 24'h2);
    rd(ADDR_DATA, 24, v);
    rd(ADDR_STATUS, 8, v);
    chk(24'(v[6]), 24'h1);
    core_range_level = 1'b0;
    conv(24'h000100, 4'h0);
    rd(ADDR_STATUS, 8, v);
    chk(24'({v[6], fault_pin_oe}), 24'h0);
    wr(ADDR_PIN_CONFIG, 16'h0810);
    for (int i = 0; i < 2; i++) begin
      fault_ext = i[0];
      repeat (6) @(negedge clk_sys);
      rd(ADDR_STATUS, 8, v);
      chk(24'(v[6]), 24'(!i[0]));
      rd(ADDR_PIN_CONFIG, 16, v);
      chk(24'(v[3]), 24'(i[0]));
    end
    wr(ADDR_IF_MODE, 16'h0020);
    wr(ADDR_ADC_MODE, 16'h2100);
    rd(ADDR_STATUS, 8, v);
    chk(24'(v[4]), 24'h1);
    wr(ADDR_IF_MODE, 16'h0000);
    rd(ADDR_STATUS, 8, v);
    chk(24'(v[4]), 24'h0);
    wr(ADDR_IF_MODE, 16'h0041);
    chan_enable = 16'h0024;
    conv(24'h1234c0, 4'h2);
    rd(ADDR_DATA, 24, v);
    chk(24'(v[23:8]), 24'h1235);
    chk(24'(v[3:0]), 24'h2);
    // Hold the pin until deselect and turn checksums on; the one later write, to the ADC mode register, fails its checksum.
    wr(ADDR_IF_MODE, 16'h0145);
    rd(ADDR_STATUS, 8, v);
    chk(24'(u_host.tail_bit), 24'h0);
    u_host.xfer(8'h01, 24'h220000, 24, v);
    rd(ADDR_STATUS, 8, v);
    chk(24'(v[5]), 24'h1);
    rd(ADDR_STATUS, 8, v);
    chk(24'(v[5]), 24'h0);
    rd(ADDR_ADC_MODE, 16, v);
    chk(v, 24'h002100);
    give_verdict();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end
endmodule

bind asfc_control asfc_control_sva #(.DELAY_CYCLES(DELAY_CYCLES), .CHANNELS(CHANNELS)) u_sva (.clk_sys(clk_sys),
  .rst(rst), .align_pin(align_pin), .dout_rdy(dout_rdy), .fault_pin_oe(fault_pin_oe),
  .aux_outputs_oe(aux_outputs_oe), .chan_enable(chan_enable), .core_reset(core_reset),
  .conv_start(conv_start), .conv_channel(conv_channel));

// File: dv/asfc_control_sva.sv
// Port assertions for the converter control block.
`timescale 1ns/1ps
module asfc_control_sva
  import asfc_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES [8] = DELAY_CYC,
  parameter int CHANNELS = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic align_pin,
  input wire logic dout_rdy,
  input wire logic fault_pin_oe,
  input wire logic aux_outputs_oe,
  input wire logic [CHANNELS-1:0] chan_enable,
  input wire logic core_reset,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel
);
  // Longest settle wait plus slack for the pin synchroniser.
  localparam int SETTLE_MAX = DELAY_CYCLES[7] + 32;

  // Lowest enabled channel, where the sequencer must restart.
  function automatic logic [3:0] first_ch(input logic [CHANNELS-1:0] m);
    first_ch = 4'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_ch = i[3:0];
      end
    end
  endfunction

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Align timing allows a few cycles for the two-flop synchroniser.
  property p_res; $fell(rst) |-> dout_rdy && core_reset && !conv_start && !fault_pin_oe && !aux_outputs_oe; endproperty
  a_res: assert property (p_res) else $error("outputs not idle after reset");
  property p_fall; $fell(align_pin) |-> ##[1:5] core_reset; endproperty
  a_fall: assert property (p_fall) else $error("align fall did not reset core");
  property p_hold; !align_pin [*6] |-> core_reset; endproperty
  a_hold: assert property (p_hold) else $error("core left reset while align low");
  property p_chan; !align_pin [*7] |-> conv_channel == first_ch(chan_enable); endproperty
  a_chan: assert property (p_chan) else $error("sequencer not at first channel");
  property p_rel; $rose(align_pin) |-> ##[2:6] !core_reset; endproperty
  a_rel: assert property (p_rel) else $error("core stayed in reset after align rise");
  property p_start; core_reset |-> !conv_start; endproperty
  a_start: assert property (p_start) else $error("start during reset");
  property p_one; conv_start |=> !conv_start; endproperty
  a_one: assert property (p_one) else $error("start pulse too long");
  property p_settle; $fell(core_reset) |-> ##[1:SETTLE_MAX] conv_start; endproperty
  a_settle: assert property (p_settle) else $error("no start after settle delay");

  c_start: cover property (conv_start);
  c_ready: cover property ($fell(dout_rdy));
  c_fault: cover property (fault_pin_oe);
endmodule

// File: dv/asfc_host_model.sv
// Serial host model that frames register transactions.
`timescale 1ns/1ps
module asfc_host_model (
  input wire logic clk_sys,
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout_rdy
);
  // Level of the shared pin just before chip select rises.
  logic tail_bit;

  // Serial clock idles high and stands still between frames.
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
  end

  // Half of a 200 ns serial period.
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask

  // Command byte then nb data bits, MSB first; read bits are taken before each rising edge.
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nb, output logic [23:0] rd);
    rd = 24'h0;
    cs_n = 1'b0;
    half();
    for (int i = 0; i < 8 + nb; i++) begin
      sclk = 1'b0;
      din = (i < 8) ? cmd[7 - i] : wd[nb + 7 - i];
      half();
      if (i >= 8) begin
        rd = {rd[22:0], dout_rdy};
      end
      sclk = 1'b1;
      half();
    end
    // Linger with select low so the pin's return to ready, or its hold, can be seen.
    half();
    half();
    tail_bit = dout_rdy;
    cs_n = 1'b1;
    din = ~din;
    half();
  endtask
endmodule

// File: hdl/asfc_control.sv
// Converter control: serial registers, alignment, delay, fault flags and aux pins.
`timescale 1ns/1ps
module asfc_control
  import asfc_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES [8] = DELAY_CYC,
  parameter int CHANNELS = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_rdy,
  input wire logic align_pin,
  input wire logic fault_pin_in,
  output logic fault_pin_out,
  output logic fault_pin_oe,
  output logic aux_out0_pin,
  output logic aux_out1_pin,
  output logic aux_outputs_oe,
  input wire logic [CHANNELS-1:0] chan_enable,
  input wire asfc_result_type core_result,
  input wire logic core_result_valid,
  input wire logic core_range_level,
  output logic core_reset,
  output logic conv_start,
  output logic [3:0] conv_channel
);
  initial begin
    if (CHANNELS < 1 || CHANNELS > 16) $error("CHANNELS must be 1 to 16");
  end

  // ****************************************
  // Pin synchronisation and edges
  // ****************************************
  logic s_sclk, s_cs_n, s_din, s_align, s_fault;
  logic sclk_d, cs_d, align_d;
  logic sclk_rise, sclk_fall, cs_rise, align_fall;

  // All five pins idle high, so the synchroniser starts from that level.
  asfc_sync #(.WIDTH(5), .IDLE(5'h1f)) pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({sclk, cs_n, din, align_pin, fault_pin_in}),
    .sync_out({s_sclk, s_cs_n, s_din, s_align, s_fault})
  );

  // Edge history starts idle-high so reset itself makes no edge.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_d <= 1'b1;
      cs_d <= 1'b1;
      align_d <= 1'b1;
    end else begin
      sclk_d <= s_sclk;
      cs_d <= s_cs_n;
      align_d <= s_align;
    end
  end

  assign sclk_rise = s_sclk & ~sclk_d & ~s_cs_n;
  assign sclk_fall = ~s_sclk & sclk_d & ~s_cs_n;
  assign cs_rise = s_cs_n & ~cs_d;
  assign align_fall = ~s_align & align_d;

  // ****************************************
  // Registers and status
  // ****************************************
  logic [15:0] adc_mode, if_mode, pin_config, watch_snap;
  logic [23:0] data_word;
  logic [3:0] status_chan;
  logic rdy_n, conv_fault, crc_fault, reg_fault, watch_d;
  logic wr_strobe, crc_fail, read_load, read_done;
  logic [5:0] cmd_addr;
  logic [23:0] wr_data;
  logic [7:0] status_byte;
  logic [1:0] fault_fn;
  logic short_word, append, watch_on, any_fault, res_take;

  assign fault_fn = pin_config[PC_FAULT_FN_LSB +: 2];
  assign short_word = if_mode[IF_SHORT_WORD];
  assign append = if_mode[IF_APPEND];
  assign watch_on = if_mode[IF_WATCH];
  assign any_fault = conv_fault | crc_fault | reg_fault;
  assign status_byte = {rdy_n, conv_fault, crc_fault, reg_fault, status_chan};

  // Register writes land only after the whole word (and checksum) arrived.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      adc_mode <= ADC_MODE_RESET;
      if_mode <= IF_MODE_RESET;
      pin_config <= PIN_CONFIG_RESET;
    end else if (wr_strobe) begin
      if (cmd_addr == ADDR_ADC_MODE) adc_mode <= wr_data[15:0];
      if (cmd_addr == ADDR_IF_MODE) if_mode <= wr_data[15:0];
      if (cmd_addr == ADDR_PIN_CONFIG) pin_config <= wr_data[15:0];
    end
  end

  // Range fault is a live level; a data read has no effect on it.
  always_ff @(posedge clk_sys) begin
    if (rst) conv_fault <= 1'b0;
    else conv_fault <= core_range_level | ((fault_fn == FN_INPUT) & ~s_fault);
  end

  // A checksum failure in the same cycle as a status read still sets the flag.
  always_ff @(posedge clk_sys) begin
    if (rst) crc_fault <= 1'b0;
    else if (crc_fail) crc_fault <= 1'b1;
    else if (read_load && cmd_addr == ADDR_STATUS) crc_fault <= 1'b0;
  end

  // Snapshot taken when watching starts; disabling the watch clears the flag.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      watch_d <= 1'b0;
      watch_snap <= '0;
      reg_fault <= 1'b0;
    end else begin
      watch_d <= watch_on;
      if (watch_on && !watch_d) watch_snap <= adc_mode ^ pin_config;
      if (!watch_on) reg_fault <= 1'b0;
      else if (watch_d && watch_snap != (adc_mode ^ pin_config)) reg_fault <= 1'b1;
    end
  end

  // New result updates data and drops ready; a data read raises ready again.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_word <= '0;
      status_chan <= '0;
      rdy_n <= 1'b1;
    end else if (res_take) begin
      status_chan <= core_result.channel;
      rdy_n <= 1'b0;
      if (short_word) begin
        // Round half up, saturating at full scale.
        if (&core_result.sample[23:8]) data_word <= {8'h00, core_result.sample[23:8]};
        else data_word <= {8'h00, core_result.sample[23:8] + 16'(core_result.sample[7])};
      end else begin
        data_word <= core_result.sample;
      end
    end else if (read_done && cmd_addr == ADDR_DATA) begin
      rdy_n <= 1'b1;
    end
  end

  // ****************************************
  // Serial link
  // ****************************************
  asfc_link_phase_type phase;
  logic [5:0] bit_cnt, xfer_len, next_len;
  logic [23:0] shift_in;
  logic [31:0] shift_out, next_word;
  logic [7:0] crc, next_crc, cmd_byte;
  logic [15:0] pin_view;
  logic dout_bit, data_mode;
  logic [7:0] return_cnt;

  assign cmd_byte = {shift_in[6:0], s_din};
  assign next_crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ s_din) ? CRC_POLY : 8'h00);

  // Level bit mirrors the pin while it is an input.
  always_comb begin
    pin_view = pin_config;
    if (fault_fn == FN_INPUT) pin_view[PC_FAULT_LEVEL] = s_fault;
  end

  // Read words are left aligned; status trails the data when appended.
  always_comb begin
    next_word = '0;
    next_len = LEN_BYTE;
    case ((phase == PH_CMD) ? cmd_byte[5:0] : cmd_addr) // The shifter moves on after the command, so use the kept address.
      ADDR_STATUS: next_word = {status_byte, 24'h000000};
      ADDR_ADC_MODE: begin
        next_word = {adc_mode, 16'h0000};
        next_len = LEN_HALF;
      end
      ADDR_IF_MODE: begin
        next_word = {if_mode, 16'h0000};
        next_len = LEN_HALF;
      end
      ADDR_REG_CHECK: begin
        next_word = {8'h00, watch_snap, 8'h00};
        next_len = LEN_WORD;
      end
      ADDR_PIN_CONFIG: begin
        next_word = {pin_view, 16'h0000};
        next_len = LEN_HALF;
      end
      ADDR_DATA: begin
        if (short_word) begin
          next_word = {data_word[15:0], status_byte, 8'h00};
          next_len = append ? LEN_WORD : LEN_HALF;
        end else begin
          next_word = {data_word, status_byte};
          next_len = append ? 6'h20 : LEN_WORD;
        end
      end
      default: next_word = '0;
    endcase
  end

  // Bits are taken on SCLK rising edges; frames restart while chip select is high.
  always_ff @(posedge clk_sys) begin
    if (rst || s_cs_n) begin
      phase <= PH_CMD;
      bit_cnt <= '0;
      crc <= '0;
      shift_in <= '0;
      xfer_len <= LEN_BYTE;
      cmd_addr <= ADDR_STATUS;
      wr_strobe <= 1'b0;
      crc_fail <= 1'b0;
      read_load <= 1'b0;
      read_done <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      crc_fail <= 1'b0;
      read_load <= 1'b0;
      read_done <= 1'b0;
      if (sclk_rise) begin
        shift_in <= {shift_in[22:0], s_din};
        crc <= next_crc;
        bit_cnt <= bit_cnt + 1'b1;
        case (phase)
          PH_CMD: begin
            if (bit_cnt == LEN_BYTE - 1'b1) begin
              bit_cnt <= '0;
              cmd_addr <= cmd_byte[5:0];
              // A command with its enable bit high is dropped.
              if (cmd_byte[7]) phase <= PH_CMD;
              else if (cmd_byte[6]) begin
                phase <= PH_RDATA;
                xfer_len <= next_len;
                read_load <= 1'b1;
              end else begin
                phase <= PH_WDATA;
                xfer_len <= (cmd_byte[5:0] == ADDR_STATUS) ? LEN_BYTE : LEN_HALF;
              end
            end
          end
          PH_WDATA: begin
            if (bit_cnt == xfer_len - 1'b1) begin
              bit_cnt <= '0;
              wr_data <= {shift_in[22:0], s_din};
              if (|if_mode[IF_CRC_EN_LSB +: 2]) phase <= PH_WCRC;
              else begin
                phase <= PH_DONE;
                wr_strobe <= 1'b1;
              end
            end
          end
          PH_WCRC: begin
            // Feeding the sent checksum through the divider leaves zero on a match.
            if (bit_cnt == LEN_BYTE - 1'b1) begin
              phase <= PH_DONE;
              wr_strobe <= (next_crc == 8'h00);
              crc_fail <= (next_crc != 8'h00);
            end
          end
          PH_RDATA: begin
            if (bit_cnt == xfer_len - 1'b1) begin
              phase <= PH_DONE;
              read_done <= 1'b1;
            end
          end
          default: phase <= PH_DONE;
        endcase
      end
    end
  end

  // Read data leaves on SCLK falling edges, MSB first; the first fall re-drives the MSB so no bit is skipped.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shift_out <= '0;
      dout_bit <= 1'b1;
    end else if (read_load) begin
      shift_out <= next_word;
      dout_bit <= next_word[31];
    end else if (sclk_fall && phase == PH_RDATA) begin
      shift_out <= {shift_out[30:0], 1'b0};
      dout_bit <= shift_out[31];
    end
  end

  // The shared pin leaves data mode after a short time, or at deselect if held.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_mode <= 1'b0;
      return_cnt <= '0;
    end else if (read_load) begin
      data_mode <= 1'b1;
      return_cnt <= '0;
    end else if (cs_rise) begin
      data_mode <= 1'b0;
    end else if (read_done && !if_mode[IF_HOLD_DOUT]) begin
      return_cnt <= 8'(DOUT_RETURN_CYC);
    end else if (return_cnt != '0) begin
      return_cnt <= return_cnt - 1'b1;
      if (return_cnt == 8'h01) data_mode <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) dout_rdy <= 1'b1;
    else dout_rdy <= data_mode ? dout_bit : rdy_n;
  end

  // ****************************************
  // Pins driven from configuration
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aux_out0_pin <= 1'b0;
      aux_out1_pin <= 1'b0;
      aux_outputs_oe <= 1'b0;
      fault_pin_out <= 1'b0;
      fault_pin_oe <= 1'b0;
    end else begin
      aux_out0_pin <= pin_config[PC_AUX0];
      aux_out1_pin <= pin_config[PC_AUX1];
      aux_outputs_oe <= pin_config[PC_GP_EN];
      case (fault_fn)
        FN_GPO: begin
          fault_pin_out <= pin_config[PC_FAULT_LEVEL];
          fault_pin_oe <= 1'b1;
        end
        FN_OPEN_DRAIN: begin
          // Only ever pulls low; the pull-up owns the high level.
          fault_pin_out <= 1'b0;
          fault_pin_oe <= any_fault;
        end
        default: begin
          fault_pin_out <= 1'b0;
          fault_pin_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Conversion sequencing and alignment
  // ****************************************
  asfc_conv_state_type state;
  logic settle_start, settle_done, align_en, stagger, multi;
  logic [3:0] first_chan, next_chan;

  assign align_en = pin_config[PC_ALIGN_EN];
  assign stagger = if_mode[IF_STAGGER];
  assign multi = $countones(chan_enable) > 1;
  assign res_take = (state == ST_CONVERT) && core_result_valid;

  // Lowest enabled channel, and the next enabled one after the current, wrapping.
  always_comb begin
    first_chan = '0;
    next_chan = '0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (chan_enable[i]) first_chan = 4'(i);
    end
    next_chan = first_chan;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (chan_enable[i] && 4'(i) > conv_channel) next_chan = 4'(i);
    end
  end

  asfc_settle_timer #(.DELAY_CYCLES(DELAY_CYCLES)) settle (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(settle_start),
    .abort(state == ST_HOLD),
    .sel(adc_mode[DELAY_LSB +: 3]),
    .done(settle_done)
  );

  // One state process drives the core's reset, start and channel select.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_HOLD;
      conv_channel <= '0;
      settle_start <= 1'b0;
      conv_start <= 1'b0;
      core_reset <= 1'b1;
    end else begin
      settle_start <= 1'b0;
      conv_start <= 1'b0;
      if (align_en && !stagger && align_fall) begin
        state <= ST_HOLD;
        conv_channel <= first_chan;
        core_reset <= 1'b1;
      end else begin
        case (state)
          ST_HOLD: begin
            // Released on the first clock after the pin is seen high.
            if (s_align || !align_en) begin
              state <= ST_SETTLE;
              settle_start <= 1'b1;
              core_reset <= 1'b0;
            end
          end
          ST_SETTLE: begin
            if (settle_done) begin
              state <= ST_CONVERT;
              conv_start <= 1'b1;
            end
          end
          ST_CONVERT: begin
            if (core_result_valid) begin
              if (stagger && !s_align) begin
                conv_channel <= next_chan;
                state <= ST_WAIT_ALIGN;
              end else if (align_en && !stagger && !multi) begin
                state <= ST_WAIT_ALIGN;
              end else begin
                conv_channel <= next_chan;
                state <= ST_SETTLE;
                settle_start <= 1'b1;
              end
            end
          end
          ST_WAIT_ALIGN: begin
            // Staggered mode resumes on align high; single-shot waits for the next fall.
            if ((stagger && s_align) || (!stagger && !align_en)) begin
              state <= ST_SETTLE;
              settle_start <= 1'b1;
            end
          end
          default: state <= ST_HOLD;
        endcase
      end
    end
  end
endmodule

// File: hdl/asfc_pkg.sv
// Shared constants, register layout and types for the converter control block.
package asfc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // Read-to-ready return time; the figure is a plain default.
  localparam int unsigned DOUT_RETURN_NS = 100;
  localparam int unsigned DOUT_RETURN_RAW = DOUT_RETURN_NS * CYC_PER_US / 1000;
  localparam int unsigned DOUT_RETURN_CYC = (DOUT_RETURN_RAW < 1) ? 1 : DOUT_RETURN_RAW;
  // Pre-sampling delay settings in microseconds, 0 us to 8 ms.
  localparam int unsigned DELAY_US [8] = '{0, 32, 128, 320, 800, 1600, 4000, 8000};
  localparam int unsigned DELAY_CYC [8] = '{DELAY_US[0] * CYC_PER_US, DELAY_US[1] * CYC_PER_US,
    DELAY_US[2] * CYC_PER_US, DELAY_US[3] * CYC_PER_US, DELAY_US[4] * CYC_PER_US,
    DELAY_US[5] * CYC_PER_US, DELAY_US[6] * CYC_PER_US, DELAY_US[7] * CYC_PER_US};

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_ADC_MODE = 6'h01;
  localparam logic [5:0] ADDR_IF_MODE = 6'h02;
  localparam logic [5:0] ADDR_REG_CHECK = 6'h03;
  localparam logic [5:0] ADDR_DATA = 6'h04;
  localparam logic [5:0] ADDR_PIN_CONFIG = 6'h06;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam logic [15:0] ADC_MODE_RESET = 16'h2000;
  localparam int DELAY_LSB = 8;
  localparam logic [15:0] IF_MODE_RESET = 16'h0000;
  localparam int IF_STAGGER = 12;
  localparam int IF_HOLD_DOUT = 8;
  localparam int IF_APPEND = 6;
  localparam int IF_WATCH = 5;
  localparam int IF_CRC_EN_LSB = 2;
  localparam int IF_SHORT_WORD = 0;
  localparam logic [15:0] PIN_CONFIG_RESET = 16'h0800;
  localparam int PC_ALIGN_EN = 11;
  localparam int PC_FAULT_FN_LSB = 4;
  localparam int PC_FAULT_LEVEL = 3;
  localparam int PC_GP_EN = 2;
  localparam int PC_AUX1 = 1;
  localparam int PC_AUX0 = 0;
  localparam logic [1:0] FN_OFF = 2'h0;
  localparam logic [1:0] FN_INPUT = 2'h1;
  localparam logic [1:0] FN_OPEN_DRAIN = 2'h2;
  localparam logic [1:0] FN_GPO = 2'h3;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_HALF = 6'h10;
  localparam logic [5:0] LEN_WORD = 6'h18;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [23:0] sample;
    logic [3:0] channel;
  } asfc_result_type;

  typedef enum logic [1:0] {ST_HOLD, ST_SETTLE, ST_CONVERT, ST_WAIT_ALIGN} asfc_conv_state_type;
  typedef enum logic [2:0] {PH_CMD, PH_WDATA, PH_WCRC, PH_RDATA, PH_DONE} asfc_link_phase_type;

endpackage

// File: hdl/asfc_settle_timer.sv
// Programmable pre-sampling delay timer.
`timescale 1ns/1ps
module asfc_settle_timer #(
  parameter int unsigned DELAY_CYCLES [8] = asfc_pkg::DELAY_CYC,
  parameter int CW = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic [2:0] sel,
  output logic done
);
  logic [CW-1:0] count;
  logic busy;

  initial begin
    for (int i = 0; i < 8; i++) begin
      if (DELAY_CYCLES[i] >= (64'd1 << CW)) $error("settle timer counter too narrow");
    end
  end

  // A zero setting still costs one cycle so the start pulse and done never coincide.
  always_ff @(posedge clk_sys) begin
    if (rst || abort) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (start) begin
      count <= CW'(DELAY_CYCLES[sel]);
      busy <= 1'b1;
      done <= 1'b0;
    end else if (busy && count == '0) begin
      busy <= 1'b0;
      done <= 1'b1;
    end else begin
      count <= busy ? count - 1'b1 : count;
      done <= 1'b0;
    end
  end
endmodule

// File: hdl/asfc_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module asfc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second stage; reset shows the pins' idle level so no false edge follows.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1 <= IDLE;
      sync_out <= IDLE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
